// File: verilog/asrbc_pkg.sv
// shared offsets, field positions, reset values and timing counts of the serial block
package asrbc_pkg;

  // register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_RXD = 4'h8;
  localparam logic [3:0] ADDR_TXD = 4'hc;

  // control register fields
  localparam int C_TE = 0;
  localparam int C_M = 1;
  localparam int C_BDE = 2;
  localparam int C_TX_POLARITY = 3;
  localparam int C_RX_POLARITY = 4;
  localparam int C_BEM_LO = 5;
  localparam int C_BEM_HI = 6;
  localparam int C_RIE = 7;
  localparam int C_PE = 8;
  localparam int C_PO = 9;

  // status register fields (flags are write-one-to-clear)
  localparam int F_FULL = 0;
  localparam int F_FE = 1;
  localparam int F_NF = 2;
  localparam int F_PERR = 3;
  localparam int F_BRK = 4;
  localparam int F_BERR = 5;

  // reset values
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [5:0] FLG_RST = 6'h00;

  // oversample positions within one bit time
  localparam logic [4:0] RT_V1 = 5'h03;
  localparam logic [4:0] RT_V2 = 5'h05;
  localparam logic [4:0] RT_V3 = 5'h07;
  localparam logic [4:0] RT_D1 = 5'h08;
  localparam logic [4:0] RT_D2 = 5'h09;
  localparam logic [4:0] RT_D3 = 5'h0a;
  localparam logic [4:0] RT_LAST = 5'h10;

  // transmit bit timing and collision compare points
  localparam logic [3:0] TX_RT_LAST = 4'hf;
  localparam logic [3:0] BEM_PT_A = 4'h9;
  localparam logic [3:0] BEM_PT_B = 4'hd;
  localparam logic [1:0] BEM_A = 2'h1;
  localparam logic [1:0] BEM_B = 2'h2;

  // character lengths: data bits and whole frame bits
  localparam logic [3:0] DBITS8 = 4'h8;
  localparam logic [3:0] DBITS9 = 4'h9;
  localparam logic [3:0] LEN8 = 4'ha;
  localparam logic [3:0] LEN9 = 4'hb;

endpackage

// File: verilog/asrbc_vote_if.sv
// three-sample vote request and answer between the receiver and the voter
`timescale 1ns/10ps
interface asrbc_vote_if;
  logic [2:0] smp;
  logic maj;
  logic noise;

  modport voter
  (
    input smp,
    output maj,
    output noise
  );

  modport user
  (
    output smp,
    input maj,
    input noise
  );
endinterface

// File: verilog/asrbc_vote.sv
// majority and disagreement of three line samples
`timescale 1ns/10ps
module asrbc_vote
(
  asrbc_vote_if.voter vif
);

  function automatic logic asrbc_majority(input logic [2:0] s);
    asrbc_majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  assign vif.maj = asrbc_majority(vif.smp);
  assign vif.noise = (vif.smp != 3'h0) && (vif.smp != 3'h7);

endmodule

// File: verilog/asrbc_sync.sv
// three-stage pin synchroniser; output moves only when stages two and three agree
`timescale 1ns/10ps
module asrbc_sync
#(
  parameter logic RST_VAL = 1'b1
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } asrbc_sync_t;

  localparam asrbc_sync_t SYNC_RST = '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};

  asrbc_sync_t r;
  asrbc_sync_t n;

  always_comb
  begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3)
    begin
      n.q = r.s3;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r <= SYNC_RST;
    end
    else
    begin
      r <= n;
    end
  end

  assign q = r.q;

endmodule

// File: verilog/asrbc_top.sv
// serial receiver with break detect, idle/preamble transmitter and collision check
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/10ps

// What this block does
// - break from start bit transfers nothing
// - mid-frame break stores partial byte with errors
// - break recognized sets the break flag
// - idle and preamble are all ones
// - idle length ten or eleven ones
// - disabling transmitter finishes current frame first
// - enable toggle queues one idle character
// - late re-enable discards pending transmit data
// - disabled and done releases the transmit pin
// - enabled collision mode compares transmit and receive
// - mismatch drives idle bit and aborts frame
// - mismatch sets flags, blocks until cleared
// - collision check off keeps its flag clear
// - eight or nine bit receive characters
// - complete frame stored, full set, request
// - sixteen ticks per bit, resync on edges
// - start search needs three ones then zero
// - start verified from samples three, five, seven
// - failed start restarts search without noise
// - data bit is majority of eight-ten
// - stop samples give framing and noise
// - start bit late samples only flag noise
module asrbc_top
  import asrbc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic oversample_tick,
  input wire logic rx_pin,
  output logic tx_out,
  output logic tx_oe_b,
  output logic rx_irq_req
);

  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_STOP, R_BRK} asrbc_rx_st_t;
  typedef enum logic [1:0] {T_IDLE, T_SEND} asrbc_tx_st_t;

  typedef struct packed {
    logic [9:0] ctrl;
    logic [5:0] flg;
    logic tx_buffer_empty;
    logic tc;
    logic [8:0] rxd;
    logic [8:0] txd;
    logic tdr_full;
    logic [15:0] rdata;
    logic irq;
    logic tx_out;
    logic tx_oe_b;
    asrbc_rx_st_t rs;
    logic [4:0] rt;
    logic [2:0] hist;
    logic [1:0] smp;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic nf_acc;
    logic last1;
    logic prev;
    logic eseen;
    logic [4:0] ecnt;
    logic [3:0] zrun;
    logic commit;
    logic brk_ev;
    asrbc_tx_st_t ts;
    logic [3:0] trt;
    logic [3:0] tbit;
    logic [10:0] tsh;
    logic frm;
    logic pre_pend;
    logic te_q;
    logic abort;
  } asrbc_state_t;

  localparam asrbc_state_t ST_RST = '{ctrl: CTRL_RST, flg: FLG_RST, tx_buffer_empty: 1'b1, tc: 1'b1,
                                      tx_out: 1'b1, tx_oe_b: 1'b1, rs: R_IDLE, ts: T_IDLE,
                                      tsh: 11'h7ff, default: '0};

  asrbc_state_t r;
  asrbc_state_t n;
  logic rx_sync;

  asrbc_vote_if vif ();

  asrbc_sync #(.RST_VAL(1'b1)) u_rx_sync
  (
    .clk(ref_clk),
    .rst_b(rst_b),
    .d(rx_pin),
    .q(rx_sync)
  );

  asrbc_vote u_vote
  (
    .vif(vif)
  );

  // modes 00 and 11 leave the collision check off
  function automatic logic bem_on(input logic [1:0] mode);
    bem_on = (mode == BEM_A) || (mode == BEM_B);
  endfunction

  always_comb
  begin
    logic char9;
    logic [3:0] nbits;
    logic [3:0] flen;
    logic rxl;
    logic [4:0] t;
    logic b;
    logic [3:0] zr;
    logic [4:0] ec;
    logic es;
    logic [8:0] dat;
    logic [3:0] pt;
    char9 = r.ctrl[C_M];
    nbits = char9 ? DBITS9 : DBITS8;
    flen = char9 ? LEN9 : LEN8;
    rxl = rx_sync ^ r.ctrl[C_RX_POLARITY];
    t = (r.rt == RT_LAST) ? 5'h01 : r.rt + 5'h01;
    b = 1'b0;
    zr = r.zrun;
    ec = r.ecnt;
    es = r.eseen;
    dat = char9 ? r.sh : {1'b0, r.sh[8:1]};
    pt = (r.ctrl[C_BEM_HI:C_BEM_LO] == BEM_A) ? BEM_PT_A : BEM_PT_B;
    // voter always sees the two stored samples plus the current one
    vif.smp = {r.smp, rxl};
    n = r;
    n.commit = 1'b0;
    n.brk_ev = 1'b0;
    n.rdata = 16'h0000;

    // flag clear first so a hardware set in the same cycle wins
    if (reg_wr && reg_addr == ADDR_STAT)
    begin
      n.flg = r.flg & ~reg_wdata[5:0];
    end

    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_CTRL: n.rdata = {6'h00, r.ctrl};
        ADDR_STAT: n.rdata = {8'h00, r.tc, r.tx_buffer_empty, r.flg};
        ADDR_RXD: n.rdata = {7'h00, r.rxd};
        default: n.rdata = 16'h0000;
      endcase
    end

    // receiver
    if (oversample_tick)
    begin
      case (r.rs)
        R_IDLE:
        begin
          n.hist = {r.hist[1:0], rxl};
          if (r.hist == 3'h7 && !rxl)
          begin
            n.rs = R_START;
            n.rt = 5'h01;
            n.nf_acc = 1'b0;
            n.smp = 2'h0;
          end
        end
        R_START:
        begin
          n.rt = t;
          if (t == RT_V1 || t == RT_V2)
          begin
            n.smp = {r.smp[0], rxl};
          end
          if (t == RT_V3)
          begin
            if (vif.maj)
            begin
              // rejected edge: back to search, noise left alone
              n.rs = R_IDLE;
              n.hist = 3'h0;
              n.rt = 5'h00;
            end
            else
            begin
              n.nf_acc = vif.noise;
            end
          end
          if (t >= RT_D1 && t <= RT_D3 && rxl)
          begin
            n.nf_acc = 1'b1;
          end
          if (t == RT_LAST)
          begin
            n.rs = R_DATA;
            n.bitn = 4'h0;
            n.zrun = 4'h1;
            n.last1 = 1'b0;
            n.eseen = 1'b0;
            n.prev = 1'b0;
          end
        end
        R_DATA, R_STOP, R_BRK:
        begin
          n.rt = t;
          n.prev = rxl;
          // remember where a falling edge follows a one bit, for resync
          if (r.last1 && !r.eseen && r.prev && !rxl)
          begin
            es = 1'b1;
            ec = 5'h01;
          end
          else if (r.eseen && r.ecnt != RT_LAST)
          begin
            ec = r.ecnt + 5'h01;
          end
          n.eseen = es;
          n.ecnt = ec;
          if (t == RT_D1 || t == RT_D2)
          begin
            n.smp = {r.smp[0], rxl};
          end
          if (t == RT_D3)
          begin
            b = vif.maj;
            zr = b ? 4'h0 : ((r.zrun == 4'hf) ? r.zrun : r.zrun + 4'h1);
            n.zrun = zr;
            n.last1 = b;
            n.eseen = 1'b0;
            if (r.last1 && !b && es)
            begin
              n.rt = ec;
            end
            if (r.rs == R_DATA)
            begin
              n.nf_acc = r.nf_acc | vif.noise;
              n.sh = {b, r.sh[8:1]};
              n.bitn = r.bitn + 4'h1;
              if (r.bitn + 4'h1 == nbits)
              begin
                n.rs = R_STOP;
              end
            end
            else if (r.rs == R_STOP)
            begin
              n.hist = 3'h0;
              if (r.ctrl[C_BDE] && !b && zr >= flen)
              begin
                // whole frame was zeros: a break, nothing stored
                n.brk_ev = 1'b1;
                n.flg[F_BRK] = 1'b1;
                n.rs = R_BRK;
              end
              else
              begin
                n.commit = 1'b1;
                n.rxd = dat;
                n.flg[F_FULL] = 1'b1;
                n.flg[F_FE] = n.flg[F_FE] | !b;
                n.flg[F_NF] = n.flg[F_NF] | r.nf_acc | vif.noise;
                n.flg[F_PERR] = n.flg[F_PERR] | (r.ctrl[C_PE] & (^dat ^ r.ctrl[C_PO]));
                n.rs = (r.ctrl[C_BDE] && !b) ? R_BRK : R_IDLE;
              end
            end
            else
            begin
              // stay here until the line returns to one
              if (b)
              begin
                n.rs = R_IDLE;
                n.hist = 3'h0;
              end
              else if (zr == flen)
              begin
                n.brk_ev = 1'b1;
                n.flg[F_BRK] = 1'b1;
              end
            end
          end
        end
        default: n.rs = R_IDLE;
      endcase
    end

    // transmitter
    n.te_q = r.ctrl[C_TE];
    if (r.ctrl[C_TE] && !r.te_q)
    begin
      n.pre_pend = 1'b1;
    end
    if (oversample_tick)
    begin
      case (r.ts)
        T_IDLE:
        begin
          if (r.ctrl[C_TE] && !r.flg[F_BERR])
          begin
            if (r.pre_pend)
            begin
              n.tsh = 11'h7ff;
              n.frm = 1'b0;
              n.ts = T_SEND;
              n.trt = 4'h0;
              n.tbit = 4'h0;
              n.pre_pend = 1'b0;
              n.tc = 1'b0;
            end
            else if (r.tdr_full)
            begin
              n.tsh = char9 ? {1'b1, r.txd, 1'b0} : {2'h3, r.txd[7:0], 1'b0};
              n.frm = 1'b1;
              n.ts = T_SEND;
              n.trt = 4'h0;
              n.tbit = 4'h0;
              n.tdr_full = 1'b0;
              n.tx_buffer_empty = 1'b1;
              n.tc = 1'b0;
            end
          end
        end
        T_SEND:
        begin
          n.trt = r.trt + 4'h1;
          if (bem_on(r.ctrl[C_BEM_HI:C_BEM_LO]) && !r.abort && r.trt == pt &&
              rxl != r.tsh[0])
          begin
            n.abort = 1'b1;
            n.tdr_full = 1'b0;
            n.flg[F_BERR] = 1'b1;
            n.tx_buffer_empty = 1'b1;
            n.tc = 1'b1;
          end
          if (r.trt == TX_RT_LAST)
          begin
            if (r.abort)
            begin
              // the idle level after abort is the high bit that follows
              n.ts = T_IDLE;
              n.abort = 1'b0;
              n.tsh = 11'h7ff;
            end
            else
            begin
              n.tsh = {1'b1, r.tsh[10:1]};
              n.tbit = r.tbit + 4'h1;
              if (r.frm && r.tbit + 4'h2 == flen && !r.ctrl[C_TE])
              begin
                // stop bit starts with the transmitter off: pending data is lost
                n.tdr_full = 1'b0;
                n.tx_buffer_empty = 1'b1;
              end
              if (r.tbit + 4'h1 == flen)
              begin
                n.ts = T_IDLE;
                n.tc = !n.tdr_full && !n.pre_pend;
              end
            end
          end
        end
        default: n.ts = T_IDLE;
      endcase
    end

    // software writes last so a same-cycle transmit load keeps the new byte
    if (reg_wr && reg_addr == ADDR_CTRL)
    begin
      n.ctrl = reg_wdata[9:0];
    end
    if (reg_wr && reg_addr == ADDR_TXD)
    begin
      n.txd = reg_wdata[8:0];
      n.tdr_full = 1'b1;
      n.tx_buffer_empty = 1'b0;
      n.tc = 1'b0;
    end
    if (!bem_on(n.ctrl[C_BEM_HI:C_BEM_LO]))
    begin
      n.flg[F_BERR] = 1'b0;
    end

    n.tx_oe_b = !((n.ts != T_IDLE) || n.ctrl[C_TE]);
    n.tx_out = ((n.ts == T_SEND) ? n.tsh[0] : 1'b1) ^ n.ctrl[C_TX_POLARITY];
    n.irq = n.flg[F_FULL] & n.ctrl[C_RIE];
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r <= ST_RST;
    end
    else
    begin
      r <= n;
    end
  end

  assign reg_rdata = r.rdata;
  assign tx_out = r.tx_out;
  assign tx_oe_b = r.tx_oe_b;
  assign rx_irq_req = r.irq;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  property p_brk_start;
    r.brk_ev && $past(r.rs) == R_STOP |-> !r.commit && !$rose(r.flg[F_FULL]);
  endproperty
  a_brk_start: assert property (p_brk_start) else $error("break stored a byte");

  property p_brk_flag;
    r.brk_ev |-> r.flg[F_BRK];
  endproperty
  a_brk_flag: assert property (p_brk_flag) else $error("break flag not set");

  property p_tx_release;
    (r.ts == T_IDLE && !r.ctrl[C_TE]) |-> tx_oe_b && tx_out == !r.ctrl[C_TX_POLARITY];
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("pin held while off");

  property p_berr_flags;
    $rose(r.flg[F_BERR]) |-> r.tc && r.abort && !$past(r.flg[F_BERR]);
  endproperty
  a_berr_flags: assert property (p_berr_flags) else $error("abort flags missing");

  property p_berr_hold;
    (r.flg[F_BERR] && r.ts == T_IDLE) |=> r.ts == T_IDLE;
  endproperty
  a_berr_hold: assert property (p_berr_hold) else $error("sent during bit error");

  property p_berr_off;
    !bem_on(r.ctrl[C_BEM_HI:C_BEM_LO]) |-> !r.flg[F_BERR];
  endproperty
  a_berr_off: assert property (p_berr_off) else $error("bit error flag while off");

  property p_irq;
    $rose(r.flg[F_FULL]) && r.ctrl[C_RIE] |-> rx_irq_req ##1 (rx_irq_req || !r.flg[F_FULL]);
  endproperty
  a_irq: assert property (p_irq) else $error("receive request missing");

  property p_reject;
    (oversample_tick && r.rs == R_START && r.rt == 5'h06 && vif.maj)
      |=> r.rs == R_IDLE && r.flg[F_NF] == $past(r.flg[F_NF]) || $past(reg_wr);
  endproperty
  a_reject: assert property (p_reject) else $error("bad start not rejected");

  property p_commit_fe;
    $rose(r.flg[F_FE]) |-> r.commit && r.flg[F_FULL];
  endproperty
  a_commit_fe: assert property (p_commit_fe) else $error("framing flag off commit");

  property p_rt_range;
    r.rt <= RT_LAST;
  endproperty
  a_rt_range: assert property (p_rt_range) else $error("oversample count overran");

endmodule

// File: test/asrbc_node.sv
// remote serial node: drives frames onto the shared line and can jam it
`timescale 1ns/10ps
module asrbc_node
(
  input wire logic clk,
  input wire logic tick,
  input wire logic tx_out,
  input wire logic tx_oe_b,
  output logic line
);
  logic drv = 1'b1;
  logic jam = 1'b0;

  // wired-and line with pull-up, so a released transmitter reads as one
  assign line = drv & ~jam & (tx_oe_b | tx_out);

  // one bit is 16 ticks; gb/gt invert a single tick to model a noise spike
  task automatic send(input logic [15:0] bits, input int n, input int gb, input int gt);
    for (int i = 0; i < n; i++)
    begin
      for (int t = 0; t < 16; t++)
      begin
        @(posedge clk iff tick);
        drv <= bits[i] ^ (i == gb && t == gt);
      end
    end
    @(posedge clk iff tick);
    drv <= 1'b1;
  endtask
endmodule

// File: test/tb_asrbc_top.sv
// self-checking bench for the serial receiver, idle transmitter and collision check
`timescale 1ns/10ps
module tb_asrbc_top;
  import asrbc_pkg::*;

  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic oversample_tick = 1'b0;
  logic rx_pin;
  logic tx_out;
  logic tx_oe_b;
  logic rx_irq_req;
  logic [1:0] tdiv = 2'h0;
  logic [15:0] v;
  logic [1:0] bm;
  logic oe;
  int n;
  int cyc = 0;
  int err_count = 0;
  int compares = 0;

  asrbc_top DUT
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .oversample_tick(oversample_tick),
    .rx_pin(rx_pin),
    .tx_out(tx_out),
    .tx_oe_b(tx_oe_b),
    .rx_irq_req(rx_irq_req)
  );

  asrbc_node partner
  (
    .clk(ref_clk),
    .tick(oversample_tick),
    .tx_out(tx_out),
    .tx_oe_b(tx_oe_b),
    .line(rx_pin)
  );

  always #5 ref_clk = ~ref_clk;

  // tick every fourth clock keeps a frame short while exercising all 16 phases
  always @(posedge ref_clk)
  begin
    tdiv <= tdiv + 2'h1;
    oversample_tick <= (tdiv == 2'h3);
  end

  task automatic give_verdict();
    if (err_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_fall(input int lim, output int k);
    k = 0;
    while (tx_out !== 1'b0 && k < lim)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
  endtask

  // one received frame: status, request level and data, then clear all flags
  task automatic rx(input logic [15:0] c, input logic [15:0] b, input int nb, input int gb,
                    input int gt, input logic [15:0] st, input logic [15:0] dat);
    wr(ADDR_CTRL, c);
    partner.send(b, nb, gb, gt);
    repeat (16) @(posedge ref_clk);
    chk({15'h0000, rx_irq_req}, {15'h0000, st[0] & c[7]});
    rd(ADDR_STAT, v);
    chk(v, st);
    rd(ADDR_RXD, v);
    chk(v, dat);
    wr(ADDR_STAT, 16'h003f);
    repeat (64) @(posedge ref_clk);
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(ADDR_CTRL, v);
    chk(v, 16'h0000);
    rd(ADDR_STAT, v);
    chk(v, 16'h00c0);
    rd(4'h2, v);
    chk(v, 16'h0000);
    // both polarities stay zero throughout
    rx(16'h0080, 16'h034a, 10, -1, 0, 16'h00c1, 16'h00a5);
    rx(16'h0082, 16'h0786, 11, -1, 0, 16'h00c1, 16'h01c3);
    rx(16'h0080, 16'h034a, 10, 2, 8, 16'h00c5, 16'h00a5);
    rx(16'h0080, 16'h034a, 10, 0, 4, 16'h00c5, 16'h00a5);
    rx(16'h0080, 16'h034a, 10, 0, 8, 16'h00c5, 16'h00a5);
    rx(16'h0080, 16'h00aa, 10, -1, 0, 16'h00c3, 16'h0055);
    rx(16'h0080, 16'h0001, 1, 0, 0, 16'h00c0, 16'h0055);
    rx(16'h0084, 16'h0000, 10, -1, 0, 16'h00d0, 16'h0055);
    rx(16'h0084, 16'h000e, 14, -1, 0, 16'h00d3, 16'h0007);
    for (int m = 0; m < 2; m++)
    begin
      wr(ADDR_CTRL, 16'h0001 | 16'(m << 1));
      wr(ADDR_TXD, 16'h01a6);
      wait_fall(2000, n);
      chk(16'(n >= 64 * (10 + m) - 4 && n <= 64 * (10 + m) + 24), 16'h0001);
      // drop the enable while the start bit is on the pin
      wr(ADDR_CTRL, 16'(m << 1));
      repeat (30) @(posedge ref_clk);
      v = 16'h0000;
      oe = 1'b0;
      for (int i = 0; i < 10 + m; i++)
      begin
        v[i] = tx_out;
        oe |= tx_oe_b;
        repeat (64) @(posedge ref_clk);
      end
      chk(v, m ? 16'h074c : 16'h034c);
      chk({15'h0000, oe}, 16'h0000);
      repeat (64) @(posedge ref_clk);
      chk({15'h0000, tx_oe_b}, 16'h0001);
      rd(ADDR_STAT, v);
      chk(v, 16'h00c1);
      rd(ADDR_RXD, v);
      chk(v, m ? 16'h01a6 : 16'h00a6);
      wr(ADDR_STAT, 16'h003f);
    end
    for (int k = 0; k < 3; k++)
    begin
      bm = (k == 2) ? 2'h0 : 2'(k + 1);
      wr(ADDR_CTRL, {9'h000, bm, 5'h01});
      wr(ADDR_TXD, 16'h000f);
      wait_fall(2000, n);
      // hold the line low across the whole first data bit, which is a one
      repeat (63) @(posedge ref_clk);
      partner.jam <= 1'b1;
      repeat (64) @(posedge ref_clk);
      partner.jam <= 1'b0;
      repeat (289) @(posedge ref_clk);
      chk({15'h0000, tx_out}, (k == 2) ? 16'h0000 : 16'h0001);
      repeat (400) @(posedge ref_clk);
      rd(ADDR_STAT, v);
      chk(v & 16'h00e0, (k == 2) ? 16'h00c0 : 16'h00e0);
      if (k == 0)
      begin
        wr(ADDR_TXD, 16'h0000);
        wait_fall(800, n);
        chk(16'(n), 16'h0320);
        wr(ADDR_STAT, 16'h0020);
        wait_fall(40, n);
        chk(16'(n < 40), 16'h0001);
        repeat (700) @(posedge ref_clk);
      end
      wr(ADDR_STAT, 16'h003f);
      wr(ADDR_CTRL, 16'h0000);
      repeat (64) @(posedge ref_clk);
    end
    give_verdict();
  end
endmodule
